// ===== mwd_cfg.svh
// Constants of the margining and supervision-timer command interpreter.
// Assumes a 100 MHz system clock and a serial link clocked by its master.
`ifndef MWD_CFG_SVH
`define MWD_CFG_SVH

// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
`define MWD_ADDR_HIGH       5'h10
`define MWD_ADDR_WIDTH      7

// ----------------------------------------------------------------------
// Command byte fields and codes
// ----------------------------------------------------------------------
`define MWD_OP_MSB          7
`define MWD_OP_LSB          5
`define MWD_VAL_MSB         4
`define MWD_OP_MARGIN       3'h1
`define MWD_OP_WDOG         3'h3
`define MWD_VAL_ARM         5'h00
`define MWD_SEL_SW_BIT      4
`define MWD_MARGIN_RSVD     4'hf
`define MWD_MARGIN_RESET    4'h0
`define MWD_WD_ON_BIT       3
`define MWD_WD_WIN_BIT      2
`define MWD_WD_SEL_RESET    2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MWD_CLK_MHZ         100
`define MWD_WD_MIN_MS       20
`define MWD_WD_MIN_CYCLES   (`MWD_WD_MIN_MS * 1000 * `MWD_CLK_MHZ)
`define MWD_LINK_CLR_CYCLES 3'h4

`endif

// ===== mwd_pkg.sv
// Types shared by the command interpreter and its link receiver.
// Assumes nothing of its surroundings.
package mwd_pkg;

    // ------------------------------------------------------------------
    // Arming state
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        mwd_arm_none,
        mwd_arm_margin,
        mwd_arm_wdog
    } mwd_arm_type;

endpackage : mwd_pkg

// ===== mwd_link_rx.sv
// Serial link receiver, clocked by the master's serial clock.
// Assumes link_clear pulses after each start while the serial clock is high.
`timescale 1ns/1ps

module mwd_link_rx
    import mwd_pkg::*;
(
    input  wire logic       scl_clk,
    input  wire logic       reset_n,
    input  wire logic       link_clear,
    input  wire logic       sda_in,
    input  wire logic [6:0] dev_addr,
    output logic            byte_toggle,
    output logic [7:0]      byte_data,
    output logic            sda_oe_n
);

    logic       frame_rst_n;
    logic [6:0] addr_meta_reg;
    logic [6:0] addr_sync_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic       addr_phase_reg;
    logic       selected_reg;
    logic       ack_pend_reg;
    logic [7:0] rx_byte;

    // A start clears the frame state; the clock is high then, so no edge
    // is lost while the clear is applied.
    assign frame_rst_n = reset_n & ~link_clear;
    assign rx_byte     = {shift_reg, sda_in};

    // ------------------------------------------------------------------
    // Device address crossing
    // ------------------------------------------------------------------
    always_ff @(posedge scl_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_meta_reg <= 7'h00;
            addr_sync_reg <= 7'h00;
        end
        else
        begin
            addr_meta_reg <= dev_addr;
            addr_sync_reg <= addr_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Bit counting and shifting
    // ------------------------------------------------------------------
    always_ff @(posedge scl_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 7'h00;
        end
        else if (bit_cnt_reg == 4'h8)
            bit_cnt_reg <= 4'h0;
        else
        begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg   <= rx_byte[6:0];
        end
    end

    // ------------------------------------------------------------------
    // Address match and acknowledge decision
    // ------------------------------------------------------------------
    always_ff @(posedge scl_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            addr_phase_reg <= 1'b1;
            selected_reg   <= 1'b0;
            ack_pend_reg   <= 1'b0;
        end
        else if (bit_cnt_reg == 4'h7)
        begin
            if (addr_phase_reg)
            begin
                addr_phase_reg <= 1'b0;
                // R3: full address compare.
                selected_reg   <= (rx_byte[7:1] == addr_sync_reg) &&
                                  !rx_byte[0];
                ack_pend_reg   <= (rx_byte[7:1] == addr_sync_reg) &&
                                  !rx_byte[0];
            end
            else
                // R6: acknowledge every byte.
                ack_pend_reg <= selected_reg;
        end
    end

    // ------------------------------------------------------------------
    // Byte hand-over
    // ------------------------------------------------------------------
    always_ff @(posedge scl_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            byte_toggle <= 1'b0;
            byte_data   <= 8'h00;
        end
        else if (bit_cnt_reg == 4'h7 && !addr_phase_reg && selected_reg &&
                 !link_clear)
        begin
            byte_toggle <= ~byte_toggle;
            byte_data   <= rx_byte;
        end
    end

    // R2: drive acknowledge bit.
    always_ff @(negedge scl_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            sda_oe_n <= 1'b1;
        else
            sda_oe_n <= !((bit_cnt_reg == 4'h8) && ack_pend_reg);
    end

    // R2: acknowledge driven low.
    a_ack_drive: assert property (@(negedge scl_clk)
        disable iff (!frame_rst_n)
        (bit_cnt_reg == 4'h8 && ack_pend_reg) |=> !sda_oe_n)
        else $error("Acknowledge not driven after matching byte.");

endmodule : mwd_link_rx

// ===== mwd_cmd_top.sv
// Command interpreter for regulator margining and the supervision timer.
// Assumes a 100 MHz clk and a serial master that writes only.
`timescale 1ns/1ps
`include "mwd_cfg.svh"

// Overview of operation
// R1: Master always addresses with write direction.
// R2: Acknowledge a matching address after start.
// R3: Address low bits come from strap pins.
// R4: Low strap gives 0, high or open 1.
// R5: Clock-mode strap sets sync pin direction.
// R6: Several command bytes, each one acknowledged.
// R7: Byte is 3-bit operation, 5-bit value.
// R8: Operations 001 margining, 011 timer programming.
// R9: Zero value arms its operation.
// R10: Execute only after matching arming byte.
// R11: Margin selects regulator and percent step.
// R12: Timer off, window mode and period.
// R13: Valid timer command starts the timer.
// R14: Stop returns interpreter to idle.
// R15: Two timer arming bytes switch timer off.
// R16: Timer command reloads only in open window.
// R17: One arming byte may precede two margins.
// R18: Unknown or reserved bytes change nothing; unknown operations and reserved timer values clear the arming state.
// R19: Elapsed period raises one timeout pulse.
module mwd_cmd_top
    import mwd_pkg::*;
#(
    parameter int unsigned WD_MIN_CYCLES = `MWD_WD_MIN_CYCLES
)
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic scl_clk,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    input  wire logic clock_mode_strap_pin,
    input  wire logic strap_address_bit_low,
    output logic      oscillator_sync_is_output,
    output logic [3:0] linear_regulator_margin,
    output logic [3:0] switcher_output_margin,
    output logic      supervision_timer_on,
    output logic      supervision_timer_window,
    output logic [1:0] supervision_timer_period_sel,
    output logic      supervision_timer_timeout
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic        scl_meta_reg;
    logic        scl_sync_reg;
    logic [2:0]  scl_prev_reg;
    logic        sda_meta_reg;
    logic        sda_sync_reg;
    logic        sda_prev_reg;
    logic [1:0]  strap_meta_reg;
    logic [1:0]  strap_sync_reg;
    logic        tgl_meta_reg;
    logic        tgl_sync_reg;
    logic        tgl_prev_reg;
    logic [6:0]  dev_addr_reg;
    logic [2:0]  clr_cnt_reg;
    logic        link_clear_reg;
    logic        byte_toggle;
    logic [7:0]  link_byte;
    mwd_arm_type arm_reg;
    logic [31:0] wd_cnt_reg;
    logic        start_evt;
    logic        stop_evt;
    logic        byte_stb;
    logic [2:0]  cmd_op;
    logic [4:0]  cmd_val;
    logic        accept_margin;
    logic        wd_cmd_ok;
    logic        wd_off;
    logic        window_open;
    logic        accept_wd;
    logic [31:0] period_cur;

    // The whole timer period scales from the shortest one by factors of 4.
    function automatic logic [31:0] wd_period(input logic [1:0] sel);
        logic [31:0] base;
        base = 32'(WD_MIN_CYCLES);
        case (sel)
            2'h0:    wd_period = base << 6;
            2'h1:    wd_period = base << 4;
            2'h2:    wd_period = base << 2;
            default: wd_period = base;
        endcase
    endfunction : wd_period

    // ------------------------------------------------------------------
    // Link receiver
    // ------------------------------------------------------------------
    mwd_link_rx u_link_rx
    (
        .scl_clk     (scl_clk),
        .reset_n     (reset_n),
        .link_clear  (link_clear_reg),
        .sda_in      (sda_in),
        .dev_addr    (dev_addr_reg),
        .byte_toggle (byte_toggle),
        .byte_data   (link_byte),
        .sda_oe_n    (sda_oe_n)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_meta_reg   <= 1'b1;
            scl_sync_reg   <= 1'b1;
            scl_prev_reg   <= 3'h7;
            sda_meta_reg   <= 1'b1;
            sda_sync_reg   <= 1'b1;
            sda_prev_reg   <= 1'b1;
            strap_meta_reg <= 2'h3;
            strap_sync_reg <= 2'h3;
            tgl_meta_reg   <= 1'b0;
            tgl_sync_reg   <= 1'b0;
            tgl_prev_reg   <= 1'b0;
        end
        else
        begin
            scl_meta_reg   <= scl_clk;
            scl_sync_reg   <= scl_meta_reg;
            scl_prev_reg   <= {scl_prev_reg[1:0], scl_sync_reg};
            sda_meta_reg   <= sda_in;
            sda_sync_reg   <= sda_meta_reg;
            sda_prev_reg   <= sda_sync_reg;
            strap_meta_reg <= {clock_mode_strap_pin, strap_address_bit_low};
            strap_sync_reg <= strap_meta_reg;
            tgl_meta_reg   <= byte_toggle;
            tgl_sync_reg   <= tgl_meta_reg;
            tgl_prev_reg   <= tgl_sync_reg;
        end
    end

    // Data may change between two short clock-high samples of a fast
    // link, so start and stop need the clock high for four samples.
    assign start_evt = scl_sync_reg && (&scl_prev_reg) && sda_prev_reg &&
                       !sda_sync_reg;
    assign stop_evt  = scl_sync_reg && (&scl_prev_reg) && !sda_prev_reg &&
                       sda_sync_reg;
    assign byte_stb  = tgl_sync_reg ^ tgl_prev_reg;

    // ------------------------------------------------------------------
    // Straps and pin direction
    // ------------------------------------------------------------------
    // Straps are tracked continuously; an open pin is pulled high outside.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dev_addr_reg              <= {`MWD_ADDR_HIGH, 2'h3};
            oscillator_sync_is_output <= 1'b1;
            sda_out                   <= 1'b0;
        end
        else
        begin
            // R4: strap level is bit value.
            dev_addr_reg              <= {`MWD_ADDR_HIGH, strap_sync_reg};
            // R5: sync pin direction.
            oscillator_sync_is_output <= strap_sync_reg[1];
            sda_out                   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Frame clear toward the link
    // ------------------------------------------------------------------
    // The clear lasts a few tens of ns, well inside the start hold time.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clr_cnt_reg    <= 3'h0;
            link_clear_reg <= 1'b0;
        end
        else
        begin
            if (start_evt)
                clr_cnt_reg <= `MWD_LINK_CLR_CYCLES;
            else if (clr_cnt_reg != 3'h0)
                clr_cnt_reg <= clr_cnt_reg - 3'h1;
            link_clear_reg <= start_evt || (clr_cnt_reg > 3'h1);
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // R7: operation and value fields.
    assign cmd_op  = link_byte[`MWD_OP_MSB:`MWD_OP_LSB];
    assign cmd_val = link_byte[`MWD_VAL_MSB:0];

    // R10: margin needs margin arming.
    assign accept_margin = byte_stb && cmd_op == `MWD_OP_MARGIN &&
                           cmd_val != `MWD_VAL_ARM &&
                           arm_reg == mwd_arm_margin &&
                           cmd_val[3:0] != `MWD_MARGIN_RSVD;
    // R18: reserved timer values rejected.
    assign wd_cmd_ok     = byte_stb && cmd_op == `MWD_OP_WDOG &&
                           arm_reg == mwd_arm_wdog &&
                           !cmd_val[`MWD_VAL_MSB] &&
                           cmd_val[`MWD_WD_ON_BIT];
    // R15: second arming byte stops timer.
    assign wd_off        = byte_stb && cmd_op == `MWD_OP_WDOG &&
                           cmd_val == `MWD_VAL_ARM &&
                           arm_reg == mwd_arm_wdog;
    assign period_cur    = wd_period(supervision_timer_period_sel);
    // R16: window opens in second half.
    assign window_open   = !supervision_timer_on ||
                           !supervision_timer_window ||
                           (wd_cnt_reg >= (period_cur >> 1));
    assign accept_wd     = wd_cmd_ok && window_open;

    // ------------------------------------------------------------------
    // Arming state
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            arm_reg <= mwd_arm_none;
        // R14: start or stop disarms.
        else if (start_evt || stop_evt)
            arm_reg <= mwd_arm_none;
        else if (byte_stb)
        begin
            // R8: two operation codes.
            case (cmd_op)
                // R17: margin stays armed.
                `MWD_OP_MARGIN:
                    arm_reg <= (cmd_val == `MWD_VAL_ARM ||
                                arm_reg == mwd_arm_margin) ?
                               mwd_arm_margin : mwd_arm_none;
                // R9: zero value arms.
                `MWD_OP_WDOG:
                    arm_reg <= (cmd_val == `MWD_VAL_ARM &&
                                arm_reg != mwd_arm_wdog) ?
                               mwd_arm_wdog : mwd_arm_none;
                default:
                    arm_reg <= mwd_arm_none;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Margining
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            linear_regulator_margin <= `MWD_MARGIN_RESET;
            switcher_output_margin  <= `MWD_MARGIN_RESET;
        end
        // R11: regulator select and step.
        else if (accept_margin)
        begin
            if (cmd_val[`MWD_SEL_SW_BIT])
                switcher_output_margin <= cmd_val[3:0];
            else
                linear_regulator_margin <= cmd_val[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Supervision timer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            supervision_timer_on         <= 1'b0;
            supervision_timer_window     <= 1'b0;
            supervision_timer_period_sel <= `MWD_WD_SEL_RESET;
        end
        else if (wd_off)
            supervision_timer_on <= 1'b0;
        // R12: window and period fields.
        else if (accept_wd)
        begin
            supervision_timer_on         <= 1'b1;
            supervision_timer_window     <= cmd_val[`MWD_WD_WIN_BIT];
            supervision_timer_period_sel <= cmd_val[1:0];
        end
    end

    // Timeout restarts the count, so a silent master sees one pulse per
    // period rather than a stuck level.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wd_cnt_reg                <= 32'h0;
            supervision_timer_timeout <= 1'b0;
        end
        else
        begin
            // R13: accepted command clears count.
            if (wd_off || accept_wd || !supervision_timer_on)
                wd_cnt_reg <= 32'h0;
            else if (wd_cnt_reg == period_cur - 32'h1)
                wd_cnt_reg <= 32'h0;
            else
                wd_cnt_reg <= wd_cnt_reg + 32'h1;
            // R19: single timeout pulse.
            supervision_timer_timeout <= supervision_timer_on && !wd_off &&
                                         !accept_wd &&
                                         wd_cnt_reg == period_cur - 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_margin_needs_arm: assert property ( // R10
        (byte_stb && cmd_op == `MWD_OP_MARGIN && cmd_val != `MWD_VAL_ARM &&
         arm_reg != mwd_arm_margin) |=>
        $stable(linear_regulator_margin) && $stable(switcher_output_margin))
        else $error("Margin changed without arming byte.");

    a_ldo_margin_load: assert property ( // R11
        (accept_margin && !cmd_val[`MWD_SEL_SW_BIT]) |=>
        linear_regulator_margin == $past(cmd_val[3:0]) &&
        $stable(switcher_output_margin))
        else $error("Linear regulator margin not loaded.");

    a_sw_margin_load: assert property ( // R11
        (accept_margin && cmd_val[`MWD_SEL_SW_BIT]) |=>
        switcher_output_margin == $past(cmd_val[3:0]) &&
        $stable(linear_regulator_margin))
        else $error("Switcher margin not loaded.");

    a_wd_twice_off: assert property ( // R15
        (byte_stb && arm_reg == mwd_arm_wdog && link_byte == 8'h60) |=>
        !supervision_timer_on ##1 arm_reg == mwd_arm_none ||
        !supervision_timer_on)
        else $error("Timer still on after two arming bytes.");

    a_wd_start_clear: assert property ( // R13
        accept_wd |=> supervision_timer_on && wd_cnt_reg == 32'h0 &&
        supervision_timer_period_sel == $past(cmd_val[1:0]))
        else $error("Timer not started by accepted command.");

    a_early_ignored: assert property ( // R16
        (wd_cmd_ok && !window_open) |=>
        $stable(supervision_timer_period_sel) && wd_cnt_reg != 32'h0)
        else $error("Command reloaded timer while window closed.");

    a_reserved_ignore: assert property ( // R18
        (byte_stb && cmd_op != `MWD_OP_MARGIN && cmd_op != `MWD_OP_WDOG) |=>
        $stable(linear_regulator_margin) && $stable(switcher_output_margin) &&
        $stable(supervision_timer_on) && arm_reg == mwd_arm_none)
        else $error("Unknown operation changed state.");

    a_timeout_pulse: assert property ( // R19
        supervision_timer_timeout |-> $past(supervision_timer_on) ##1
        !supervision_timer_timeout && wd_cnt_reg == 32'h1)
        else $error("Timeout not a single pulse from running timer.");

    a_stop_idle: assert property ( // R14
        (start_evt || stop_evt) |=> arm_reg == mwd_arm_none)
        else $error("Interpreter not idle after start or stop.");

    a_strap_addr: assert property ( // R3
        $stable(strap_sync_reg) [*2] |->
        dev_addr_reg == {`MWD_ADDR_HIGH, strap_sync_reg})
        else $error("Device address does not follow straps.");

    c_margin_set: cover property (accept_margin);
    c_wd_accept: cover property (accept_wd);
    c_wd_off: cover property (wd_off);
    c_timeout: cover property (supervision_timer_timeout);

endmodule : mwd_cmd_top

// ===== mwd_master_model.sv
// Write-only two-wire bus master that drives the serial clock and data.
// Assumes the data wire is resolved by the bench with a pull-up.
`timescale 1ns/1ps

module mwd_master_model
(
    output logic      scl_clk,
    output logic      sda_low,
    input  wire logic sda_in
);
    // The serial clock stands high between frames; bits last 12 ns.
    initial
    begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start_cond();
        sda_low = 1'b1;
        #100;
        scl_clk = 1'b0;
        #3;
    endtask : start_cond

    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_low = ~b[i];
            #3 scl_clk = 1'b1;
            #6 scl_clk = 1'b0;
            #3;
        end
        sda_low = 1'b0;
        #3 ack = (sda_in === 1'b0);
        scl_clk = 1'b1;
        #6 scl_clk = 1'b0;
        #3;
    endtask : send

    task automatic stop_cond();
        sda_low = 1'b1;
        #3 scl_clk = 1'b1;
        // The clock stands high long enough for the stop to be seen.
        #40 sda_low = 1'b0;
        #100;
    endtask : stop_cond
endmodule : mwd_master_model

// ===== tb_top.sv
// Self-checking bench for the margining and supervision timer interpreter.
// Assumes the master model above and a short timer period of 40 cycles.
`timescale 1ns/1ps
`include "mwd_cfg.svh"

module tb_top;
    logic       clk, reset_n, strap_hi, strap_lo, scl_clk, sda_low, sda_in;
    logic       sda_out, sda_oe_n, osc_out, wd_on, wd_win, wd_to;
    logic [3:0] lin, sw;
    logic [1:0] wd_sel;
    int         n_fail = 0;
    int         num_checks = 0;

    // Pull-up on the data wire; either party may pull it low.
    assign sda_in = ~sda_low & (sda_oe_n | sda_out);

    mwd_master_model i_mwd_master_model (.scl_clk(scl_clk),
        .sda_low(sda_low), .sda_in(sda_in));

    mwd_cmd_top #(.WD_MIN_CYCLES(40)) i_mwd_cmd_top (.clk(clk),
        .reset_n(reset_n), .scl_clk(scl_clk), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .clock_mode_strap_pin(strap_hi), .strap_address_bit_low(strap_lo),
        .oscillator_sync_is_output(osc_out), .linear_regulator_margin(lin),
        .switcher_output_margin(sw), .supervision_timer_on(wd_on),
        .supervision_timer_window(wd_win),
        .supervision_timer_period_sel(wd_sel),
        .supervision_timer_timeout(wd_to));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic chk(input string w, input logic [7:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    function automatic logic [7:0] adr(input logic [1:0] lo, input logic rw);
        return {`MWD_ADDR_HIGH, lo, rw};
    endfunction : adr

    task automatic frame(input logic [7:0] ab, b0, b1, b2, input int n,
                         input logic ack_exp);
        logic a;
        i_mwd_master_model.start_cond();
        i_mwd_master_model.send(ab, a);
        chk("addr_ack", {7'h0, ack_exp}, {7'h0, a});
        for (int k = 0; k < n; k++)
        begin
            i_mwd_master_model.send(k == 0 ? b0 : k == 1 ? b1 : b2, a);
            chk("data_ack", 8'h01, {7'h0, a});
        end
        i_mwd_master_model.stop_cond();
        repeat (8) @(negedge clk);
    endtask : frame

    // The timeout must be a single pulse within five short periods.
    task automatic wait_to();
        for (int i = 0; i < 200 && wd_to !== 1'b1; i++) @(negedge clk);
        chk("timeout", 8'h01, {7'h0, wd_to});
        @(negedge clk);
        chk("timeout_len", 8'h00, {7'h0, wd_to});
    endtask : wait_to

    task automatic chk_wd(input logic on, win, input logic [1:0] sel);
        chk("wd_on", {7'h0, on}, {7'h0, wd_on});
        chk("wd_win", {7'h0, win}, {7'h0, wd_win});
        chk("wd_sel", {6'h0, sel}, {6'h0, wd_sel});
    endtask : chk_wd

    initial
    begin
        reset_n <= 1'b0;
        strap_hi <= 1'b1;
        strap_lo <= 1'b1;
        repeat (12) @(posedge clk);
        chk("osc_out", 8'h01, {7'h0, osc_out});
        chk("margins", 8'h00, {lin, sw});
        chk_wd(1'b0, 1'b0, 2'h0);
        reset_n <= 1'b1;
        repeat (8) @(negedge clk);
        frame(adr(2'h0, 1'b0), 8'h00, 8'h00, 8'h00, 0, 1'b0);
        frame(adr(2'h3, 1'b1), 8'h00, 8'h00, 8'h00, 0, 1'b0);
        frame(adr(2'h3, 1'b0), 8'h20, 8'h25, 8'h3c, 3, 1'b1);
        chk("margins", 8'h5c, {lin, sw});
        frame(adr(2'h3, 1'b0), 8'h27, 8'h20, 8'h2f, 3, 1'b1);
        frame(adr(2'h3, 1'b0), 8'h20, 8'h40, 8'h21, 3, 1'b1);
        chk("margins", 8'h5c, {lin, sw});
        frame(adr(2'h3, 1'b0), 8'h60, 8'h6f, 8'h00, 2, 1'b1);
        chk_wd(1'b1, 1'b1, 2'h3);
        wait_to();
        // An early command lands while the window is still shut.
        frame(adr(2'h3, 1'b0), 8'h60, 8'h6b, 8'h00, 2, 1'b1);
        chk_wd(1'b1, 1'b1, 2'h3);
        wait_to();
        repeat (24) @(negedge clk);
        frame(adr(2'h3, 1'b0), 8'h60, 8'h60, 8'h00, 2, 1'b1);
        chk("wd_on", 8'h00, {7'h0, wd_on});
        for (int k = 0; k < 4; k++)
        begin
            frame(adr(2'h3, 1'b0), 8'h60, 8'h68 | 8'(k), 8'h00, 2,
                  1'b1);
            chk_wd(1'b1, 1'b0, 2'(k));
        end
        @(posedge clk);
        strap_hi <= 1'b0;
        strap_lo <= 1'b0;
        repeat (6) @(negedge clk);
        chk("osc_out", 8'h00, {7'h0, osc_out});
        frame(adr(2'h0, 1'b0), 8'h20, 8'h2e, 8'h00, 2, 1'b1);
        chk("margins", 8'hec, {lin, sw});
        close_out();
    end

    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end
endmodule : tb_top
